/* File: ebtp_pkg.sv */
// Constants and types for the eight-bit timer pair block.
// Assumes one peripheral clock domain and an APB register port.
package ebtp_pkg;

    // ==========
    // Register map (byte offsets)
    localparam logic [7:0]  CH_AREA     = 8'h40;
    localparam logic [7:0]  ALIGN_MASK  = 8'h03;
    localparam logic [7:0]  REG_MASK    = 8'h0F;
    localparam int          CH_SEL_LSB  = 4;
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_COUNT   = 8'h04;
    localparam logic [7:0]  OFS_CMPA    = 8'h08;
    localparam logic [7:0]  OFS_CMPB    = 8'h0C;
    localparam logic [7:0]  OFS_STATUS  = 8'h40;
    localparam logic [7:0]  OFS_MASK    = 8'h44;
    localparam logic [7:0]  OFS_UNIT    = 8'h48;

    // ==========
    // Channel control fields
    localparam int CTRL_W     = 12;
    localparam int CKS_LSB    = 0;
    localparam int CCLR_LSB   = 4;
    localparam int LNK_LSB    = 6;
    localparam int OUTA_LSB   = 8;
    localparam int OUTB_LSB   = 10;
    localparam int RUN_BIT    = 12;

    // ==========
    // Unit configuration fields
    localparam int UNIT_W      = 11;
    localparam int MODE_LSB    = 0;
    localparam int STOP_BIT    = 4;
    localparam int ADC_SEL_BIT = 6;
    localparam int SCLK_LSB    = 7;
    localparam int RCLK_LSB    = 9;
    localparam int ADC_CH_LO   = 0;
    localparam int ADC_CH_HI   = 2;

    // ==========
    // Status layout: three flags per channel
    localparam int ST_W      = 12;
    localparam int ST_STRIDE = 3;
    localparam int ST_A      = 0;

    // ==========
    // Reset values and counter limits
    localparam logic [7:0]  CMP_RST  = 8'hFF;
    localparam logic [7:0]  CNT_MAX  = 8'hFF;
    localparam logic [7:0]  CNT_ZERO = 8'h00;

    // ==========
    // Prescaler taps: tick when the low bits are all ones
    localparam logic [12:0] MASK_DIV1    = 13'h0000;
    localparam logic [12:0] MASK_DIV2    = 13'h0001;
    localparam logic [12:0] MASK_DIV8    = 13'h0007;
    localparam logic [12:0] MASK_DIV32   = 13'h001F;
    localparam logic [12:0] MASK_DIV64   = 13'h003F;
    localparam logic [12:0] MASK_DIV1024 = 13'h03FF;
    localparam logic [12:0] MASK_DIV8192 = 13'h1FFF;

    // ==========
    // Encodings
    typedef enum logic [3:0] {
        CKS_OFF = 4'h0, CKS_D1 = 4'h1, CKS_D2 = 4'h2,
        CKS_D8 = 4'h3, CKS_D32 = 4'h4, CKS_D64 = 4'h5,
        CKS_D1K = 4'h6, CKS_D8K = 4'h7, CKS_EXT = 4'h8
    } ebtp_cks_e;
    typedef enum logic [1:0] {
        CLR_NONE = 2'b00, CLR_A = 2'b01, CLR_B = 2'b10, CLR_EXT = 2'b11
    } ebtp_clr_e;
    typedef enum logic [1:0] {
        LNK_NONE = 2'b00, LNK_START = 2'b01, LNK_COUNT = 2'b10, LNK_RESTART = 2'b11
    } ebtp_lnk_e;
    typedef enum logic [1:0] {
        OUT_HOLD = 2'b00, OUT_LOW = 2'b01, OUT_HIGH = 2'b10, OUT_TOGGLE = 2'b11
    } ebtp_out_e;
    typedef enum logic [1:0] {
        MODE_INDEP = 2'b00, MODE_16BIT = 2'b01, MODE_CMCNT = 2'b10
    } ebtp_mode_e;

endpackage : ebtp_pkg

/* File: ebtp_top.sv */
// Two units of two 8-bit timer channels, APB register port.
// Assumes pins on ext_count_clk/ext_count_rst are asynchronous and
// link_event_in comes from logic on pclk as one-cycle pulses.
//
// Operation
// - Count prescaled pclk (1,2,8,32,64,1024,8192) or external clock, selectable.
// - Two units, each of two channels with own 8-bit counter.
// - Compare match A and B in 8-bit and cascaded 16-bit operation.
// - Counter clear from match A, match B or external reset input.
// - Each channel drives a pulse or PWM output from its matches.
// - 16-bit mode: channel zero upper byte, channel one lower; same for two/three.
// - Match count mode: channel one counts channel zero match A events.
// - Separate maskable flags for match A, match B, overflow, sharing one irq line.
// - All channels pulse link outputs for match A, match B, overflow.
// - Incoming link event starts, clocks or restarts the counter as configured.
// - Match A and B interrupt requests trigger the transfer controller.
// - Match A of channel zero or two starts the converter.
// - Timer generates the serial interface basic clock.
// - Timer generates the remote control receiver operating clock.
// - Each unit has its own stop state halting its counting.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module ebtp_top
    import ebtp_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer pins
    input  wire logic [3:0]  ext_count_clk,
    input  wire logic [3:0]  ext_count_rst,
    output logic      [3:0]  timer_out,
    // Incoming link events
    input  wire logic [3:0]  link_event_in,
    // Outgoing events and triggers
    output logic      [3:0]  link_cma,
    output logic      [3:0]  link_cmb,
    output logic      [3:0]  link_ovf,
    output logic      [3:0]  dtc_req_a,
    output logic      [3:0]  dtc_req_b,
    output logic             adc_start,
    output logic             serial_clk,
    output logic             remote_clk,
    output logic             irq
);

    // ==========
    // State
    typedef struct packed {
        logic [3:0][CTRL_W-1:0] ctrl;
        logic [3:0]             run;
        logic [3:0][7:0]        cnt;
        logic [3:0][7:0]        cmpa;
        logic [3:0][7:0]        cmpb;
        logic [ST_W-1:0]        status;
        logic [ST_W-1:0]        mask;
        logic [UNIT_W-1:0]      unit;
        logic [12:0]            pre;
        logic [3:0]             xc_s1;
        logic [3:0]             xc_s2;
        logic [3:0]             xc_s3;
        logic [3:0]             xr_s1;
        logic [3:0]             xr_s2;
        logic [3:0]             xr_s3;
        logic [3:0]             tout;
        logic [3:0]             ev_a;
        logic [3:0]             ev_b;
        logic [3:0]             ev_o;
        logic [3:0]             dtc_a;
        logic [3:0]             dtc_b;
        logic                   adc;
        logic                   sclk;
        logic                   rclk;
        logic [31:0]            rdata;
        logic                   err;
    } ebtp_state_s;

    ebtp_state_s s;
    ebtp_state_s next_s;

    // ==========
    // Helpers
    // Source enable for one channel
    function automatic logic src_tick(input logic [3:0] cks, input logic [12:0] pre, input logic xedge);
        logic [12:0] m;
        logic        t;
        m = MASK_DIV1;
        t = 1'b0;
        case (cks)
            CKS_D1:  m = MASK_DIV1;
            CKS_D2:  m = MASK_DIV2;
            CKS_D8:  m = MASK_DIV8;
            CKS_D32: m = MASK_DIV32;
            CKS_D64: m = MASK_DIV64;
            CKS_D1K: m = MASK_DIV1024;
            CKS_D8K: m = MASK_DIV8192;
            default: m = MASK_DIV1;
        endcase
        case (cks)
            CKS_OFF: t = 1'b0;
            CKS_EXT: t = xedge;
            CKS_D1, CKS_D2, CKS_D8, CKS_D32, CKS_D64, CKS_D1K, CKS_D8K:
                t = ((pre & m) == m);
            default: t = 1'b0;
        endcase
        return t;
    endfunction : src_tick

    // One 8-bit channel step: {next count, overflow, match B, match A}
    function automatic logic [10:0] chan_step(input logic [7:0] cnt, input logic [7:0] a,
                                              input logic [7:0] b, input logic [1:0] cclr,
                                              input logic tick, input logic xrst, input logic rst);
        logic       ma;
        logic       mb;
        logic       ov;
        logic       clr;
        logic [7:0] nc;
        ma = tick && (cnt == a);
        mb = tick && (cnt == b);
        case (cclr)
            CLR_A:   clr = ma;
            CLR_B:   clr = mb;
            CLR_EXT: clr = xrst;
            default: clr = 1'b0;
        endcase
        clr = clr | rst;
        ov = tick && (cnt == CNT_MAX) && !clr;
        nc = clr ? CNT_ZERO : 8'(cnt + {7'h00, tick});
        return {nc, ov, mb, ma};
    endfunction : chan_step

    // Output pin action on a match
    function automatic logic out_act(input logic cur, input logic [1:0] act);
        logic v;
        case (act)
            OUT_LOW:    v = 1'b0;
            OUT_HIGH:   v = 1'b1;
            OUT_TOGGLE: v = !cur;
            default:    v = cur;
        endcase
        return v;
    endfunction : out_act

    // ==========
    // Combinational working signals
    logic [3:0]        tick;
    logic [3:0]        ma;
    logic [3:0]        mb;
    logic [3:0]        ov;
    logic [3:0]        rst;
    logic [3:0][7:0]   nc;
    logic [3:0]        xc_edge;
    logic [3:0]        xr_edge;
    logic [1:0]        md;
    logic              stp;
    logic              clr16;
    logic              carry;
    logic [ST_W-1:0]   st_set;
    logic [ST_W-1:0]   st_clr;
    logic [1:0]        apb_ch;
    logic [7:0]        apb_rg;
    logic              is_ch;
    logic              aligned;
    logic              wr;

    // ==========
    // Next-state logic
    always_comb
    begin
        int e;
        int o;
        logic t;
        e       = 0;
        o       = 0;
        t       = 1'b0;
        next_s  = s;
        tick    = '0;
        ma      = '0;
        mb      = '0;
        ov      = '0;
        rst     = '0;
        nc      = s.cnt;
        md      = MODE_INDEP;
        stp     = 1'b0;
        clr16   = 1'b0;
        carry   = 1'b0;
        st_set  = '0;
        st_clr  = '0;

        // Synchronisers and edges; stages two and three feed the edge detect
        next_s.xc_s1 = ext_count_clk;
        next_s.xc_s2 = s.xc_s1;
        next_s.xc_s3 = s.xc_s2;
        next_s.xr_s1 = ext_count_rst;
        next_s.xr_s2 = s.xr_s1;
        next_s.xr_s3 = s.xr_s2;
        xc_edge = s.xc_s2 & ~s.xc_s3;
        xr_edge = s.xr_s2 & ~s.xr_s3;

        // Free-running prescaler shared by both units
        next_s.pre = 13'(s.pre + 13'h0001);

        // Per unit: even channel is the upper byte, odd the lower
        for (int u = 0; u < 2; u++)
        begin
            e   = 2 * u;
            o   = e + 1;
            md  = s.unit[MODE_LSB + 2 * u +: 2];
            stp = s.unit[STOP_BIT + u];
            for (int c = e; c <= o; c++)
            begin
                tick[c] = (src_tick(s.ctrl[c][CKS_LSB +: 4], s.pre, xc_edge[c]) |
                           ((s.ctrl[c][LNK_LSB +: 2] == LNK_COUNT) & link_event_in[c]))
                          & s.run[c] & ~stp;
                rst[c]  = (s.ctrl[c][LNK_LSB +: 2] == LNK_RESTART) & link_event_in[c];
            end
            {nc[e], ov[e], mb[e], ma[e]} = chan_step(s.cnt[e], s.cmpa[e], s.cmpb[e],
                s.ctrl[e][CCLR_LSB +: 2], tick[e], xr_edge[e], rst[e]);
            // Lower channel clocked by upper match A
            if (md == MODE_CMCNT)
            begin
                tick[o] = ma[e] & s.run[o] & ~stp;
            end
            {nc[o], ov[o], mb[o], ma[o]} = chan_step(s.cnt[o], s.cmpa[o], s.cmpb[o],
                s.ctrl[o][CCLR_LSB +: 2], tick[o], xr_edge[o], rst[o]);
            // Cascade: lower channel's clock drives the pair
            if (md == MODE_16BIT)
            begin
                ma[e] = tick[o] && ({s.cnt[e], s.cnt[o]} == {s.cmpa[e], s.cmpa[o]});
                mb[e] = tick[o] && ({s.cnt[e], s.cnt[o]} == {s.cmpb[e], s.cmpb[o]});
                case (s.ctrl[e][CCLR_LSB +: 2])
                    CLR_A:   clr16 = ma[e];
                    CLR_B:   clr16 = mb[e];
                    CLR_EXT: clr16 = xr_edge[e];
                    default: clr16 = 1'b0;
                endcase
                clr16 = clr16 | rst[e] | rst[o];
                carry = tick[o] && (s.cnt[o] == CNT_MAX);
                ov[e] = carry && (s.cnt[e] == CNT_MAX) && !clr16;
                ov[o] = carry && !clr16;
                nc[e] = clr16 ? CNT_ZERO : 8'(s.cnt[e] + {7'h00, carry});
                nc[o] = clr16 ? CNT_ZERO : 8'(s.cnt[o] + {7'h00, tick[o]});
            end
        end

        // Per channel effects of the step
        for (int c = 0; c < 4; c++)
        begin
            next_s.cnt[c] = nc[c];
            t = s.tout[c];
            if (ma[c])
            begin
                t = out_act(t, s.ctrl[c][OUTA_LSB +: 2]);
            end
            if (mb[c])
            begin
                t = out_act(t, s.ctrl[c][OUTB_LSB +: 2]); // B wins, gives PWM fall
            end
            next_s.tout[c] = t;
            st_set[c * ST_STRIDE +: ST_STRIDE] = {ov[c], mb[c], ma[c]};
            next_s.dtc_a[c] = ma[c] & s.mask[c * ST_STRIDE + ST_A];
            next_s.dtc_b[c] = mb[c] & s.mask[c * ST_STRIDE + ST_A + 1];
        end
        next_s.ev_a = ma;
        next_s.ev_b = mb;
        next_s.ev_o = ov;
        next_s.adc  = s.unit[ADC_SEL_BIT] ? ma[ADC_CH_HI] : ma[ADC_CH_LO];
        // Divided clocks toggle on match A of the chosen channel
        if (ma[s.unit[SCLK_LSB +: 2]])
        begin
            next_s.sclk = !s.sclk;
        end
        if (ma[s.unit[RCLK_LSB +: 2]])
        begin
            next_s.rclk = !s.rclk;
        end

        // APB decode
        apb_ch  = paddr[CH_SEL_LSB +: 2];
        apb_rg  = paddr & REG_MASK;
        is_ch   = (paddr < CH_AREA);
        aligned = ((paddr & ALIGN_MASK) == '0);
        wr      = psel & penable & pwrite;

        // Read data captured in the setup cycle, shown in access
        if (psel && !penable)
        begin
            next_s.rdata = '0;
            next_s.err   = !aligned;
            if (is_ch)
            begin
                case (apb_rg)
                    OFS_CTRL:  next_s.rdata = {19'h0, s.run[apb_ch], s.ctrl[apb_ch]};
                    OFS_COUNT: next_s.rdata = {24'h0, s.cnt[apb_ch]};
                    OFS_CMPA:  next_s.rdata = {24'h0, s.cmpa[apb_ch]};
                    OFS_CMPB:  next_s.rdata = {24'h0, s.cmpb[apb_ch]};
                    default:   next_s.err   = 1'b1;
                endcase
            end
            else
            begin
                case (paddr)
                    OFS_STATUS: next_s.rdata = {20'h0, s.status};
                    OFS_MASK:   next_s.rdata = {20'h0, s.mask};
                    OFS_UNIT:   next_s.rdata = {21'h0, s.unit};
                    default:    next_s.err   = 1'b1;
                endcase
            end
        end

        // Writes take effect in the access cycle; software beats counting
        if (wr && aligned)
        begin
            if (is_ch)
            begin
                case (apb_rg)
                    OFS_CTRL:
                    begin
                        next_s.ctrl[apb_ch] = pwdata[CTRL_W-1:0];
                        next_s.run[apb_ch]  = pwdata[RUN_BIT];
                    end
                    OFS_COUNT: next_s.cnt[apb_ch]  = pwdata[7:0];
                    OFS_CMPA:  next_s.cmpa[apb_ch] = pwdata[7:0];
                    OFS_CMPB:  next_s.cmpb[apb_ch] = pwdata[7:0];
                    default:   next_s.err = s.err;
                endcase
            end
            else
            begin
                case (paddr)
                    OFS_STATUS: st_clr      = pwdata[ST_W-1:0];
                    OFS_MASK:   next_s.mask = pwdata[ST_W-1:0];
                    OFS_UNIT:   next_s.unit = pwdata[UNIT_W-1:0];
                    default:    next_s.err  = s.err;
                endcase
            end
        end

        // Link start after software so a same-cycle start is kept
        for (int c = 0; c < 4; c++)
        begin
            if ((s.ctrl[c][LNK_LSB +: 2] == LNK_START) && link_event_in[c])
            begin
                next_s.run[c] = 1'b1;
            end
        end

        // Sticky flags: a new event beats a write-one clear
        next_s.status = (s.status & ~st_clr) | st_set;
    end

    // ==========
    // State register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s      <= '0;
            s.cmpa <= {4{CMP_RST}};
            s.cmpb <= {4{CMP_RST}};
        end
        else
        begin
            s <= next_s;
        end
    end

    // ==========
    // Outputs
    assign prdata     = s.rdata;
    assign pready     = psel & penable;                  // No wait states
    assign pslverr    = s.err & psel & penable;
    assign timer_out  = s.tout;
    assign link_cma   = s.ev_a;
    assign link_cmb   = s.ev_b;
    assign link_ovf   = s.ev_o;
    assign dtc_req_a  = s.dtc_a;
    assign dtc_req_b  = s.dtc_b;
    assign adc_start  = s.adc;
    assign serial_clk = s.sclk;
    assign remote_clk = s.rclk;
    assign irq        = |(s.status & s.mask);

endmodule : ebtp_top

`default_nettype wire

/* File: ebtp_properties.sv */
// Port-level checks for the eight-bit timer pair.
// Assumes a bind onto ebtp_top in the single pclk domain.
`timescale 1ns/1ps
`default_nettype none
module ebtp_props
    import ebtp_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // Register bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Timer outputs and triggers
    input wire logic [3:0]  timer_out,
    input wire logic [3:0]  link_cma,
    input wire logic [3:0]  link_cmb,
    input wire logic [3:0]  link_ovf,
    input wire logic [3:0]  dtc_req_a,
    input wire logic [3:0]  dtc_req_b,
    input wire logic        adc_start,
    input wire logic        serial_clk,
    input wire logic        remote_clk,
    input wire logic        irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========
    // Bus phases and match events
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_hit;
        |link_cma;
    endsequence
    // Zero-wait answer, silent outside the access phase
    a_ready_access: assert property (s_access |-> pready)
        else $error("no ready in access phase");
    a_bus_quiet: assert property (!(psel && penable) |-> !pready && !pslverr)
        else $error("bus answer outside access");
    a_refused_read: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    // Triggers only ever follow a match; the clock checks take a match on any channel
    a_adc_source: assert property (adc_start |-> link_cma[0] || link_cma[2])
        else $error("converter start without match");
    a_dtc_a_gate: assert property ((dtc_req_a & ~link_cma) == 4'h0)
        else $error("transfer request A without match");
    a_dtc_b_gate: assert property ((dtc_req_b & ~link_cmb) == 4'h0)
        else $error("transfer request B without match");
    a_serial_match: assert property (!$stable(serial_clk) |-> s_hit)
        else $error("serial clock moved without match");
    a_remote_match: assert property (!$stable(remote_clk) |-> s_hit)
        else $error("remote clock moved without match");
    a_out_match: assert property (((timer_out ^ $past(timer_out)) & ~(link_cma | link_cmb)) == 4'h0)
        else $error("timer output moved without match");
    // Interrupt line moves only on a write or a fresh event
    a_irq_fall: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
        else $error("interrupt dropped without write");
    a_irq_rise: assert property ($rose(irq) |-> $past(psel && penable && pwrite) || (|{link_cma, link_cmb, link_ovf}))
        else $error("interrupt rose without cause");
endmodule : ebtp_props
`default_nettype wire

/* File: ebtp_far.sv */
// Far-side model: event link source and counters of the block's pulses.
// Assumes the bench raises evt_req for exactly one pclk cycle per event.
`timescale 1ns/1ps
`default_nettype none
module ebtp_far
    import ebtp_pkg::*;
(
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Event requests from the bench
    input  wire logic [3:0] evt_req,
    // Pulses from the block
    input  wire logic [3:0] link_cma,
    input  wire logic [3:0] link_ovf,
    input  wire logic       adc_start,
    // Link events into the block
    output logic      [3:0] link_event_in
);
    int cyc = 0;
    int cnt_ovf = 0;
    int cnt_adc = 0;
    int cnt_a [4];
    int last_a [4];
    int gap_a [4];

    // ==========
    // Registered one-cycle pulses, as link logic on pclk delivers them
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            link_event_in <= 4'h0;
        else
            link_event_in <= evt_req;

    // ==========
    // Consumers count pulses; the gap is what a period check needs
    always @(posedge pclk)
    begin
        cyc++;
        cnt_ovf += $countones(link_ovf);
        cnt_adc += (adc_start === 1'b1) ? 1 : 0;
        for (int c = 0; c < 4; c++)
            if (link_cma[c] === 1'b1)
            begin
                gap_a[c] = cyc - last_a[c];
                last_a[c] = cyc;
                cnt_a[c]++;
            end
    end
endmodule : ebtp_far
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the eight-bit timer pair.
// Assumes ebtp_top, ebtp_props and ebtp_far are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ebtp_pkg::*;
;
    typedef struct packed { logic [3:0] cks; logic [7:0] cmp; logic [15:0] gap; } ebtp_row_s;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, base;
    logic [31:0] pwdata = 32'h0, prdata, rd_data;
    logic        pready, pslverr, rd_err, adc_start, serial_clk, remote_clk, irq;
    logic [3:0]  ext_count_clk = 4'h0, ext_count_rst = 4'h0, evt_req = 4'h0, link_event_in, timer_out;
    logic [3:0]  link_cma, link_cmb, link_ovf, dtc_req_a, dtc_req_b;
    int          err_count = 0, check_count = 0, mark;
    // Tap, compare value, expected match period in pclk cycles
    ebtp_row_s   rows [7] = '{'{CKS_D1, 8'h03, 16'h0004}, '{CKS_D2, 8'h03, 16'h0008},
        '{CKS_D8, 8'h01, 16'h0010}, '{CKS_D32, 8'h01, 16'h0040}, '{CKS_D64, 8'h00, 16'h0040},
        '{CKS_D1K, 8'h01, 16'h0800}, '{CKS_D8K, 8'h00, 16'h2000}};

    // ==========
    // Block under test and its far side
    ebtp_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .ext_count_clk, .ext_count_rst, .timer_out, .link_event_in, .link_cma, .link_cmb,
        .link_ovf, .dtc_req_a, .dtc_req_b, .adc_start, .serial_clk, .remote_clk, .irq);
    ebtp_far u_far (.pclk, .presetn, .evt_req, .link_cma, .link_ovf, .adc_start, .link_event_in);

    // 50 MHz clock
    always #10 pclk = ~pclk;

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // One APB transfer; held until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_data, exp);
    endtask : rdc

    // Single link event; a low cycle keeps pulses apart
    task automatic evt(input logic [3:0] m);
        evt_req <= m;
        @(posedge pclk);
        evt_req <= 4'h0;
        @(posedge pclk);
    endtask : evt

    task automatic complete_run;
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    // Watchdog sized well above the slowest tap's three periods
    initial
    begin
        repeat (60000) @(posedge pclk);
        err_count++;
        complete_run();
    end

    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // Period of a cleared-on-A count, each tap, channels in turn
        for (int i = 0; i < 7; i++)
        begin
            base = 8'(i % 4) << 4;
            wr(base | OFS_COUNT, 32'h0);
            wr(base | OFS_CMPA, {24'h0, rows[i].cmp});
            wr(base | OFS_CTRL, 32'h1310 | {28'h0, rows[i].cks});
            mark = u_far.cnt_a[i % 4] + 3;
            while (u_far.cnt_a[i % 4] < mark)
                @(posedge pclk);
            chk("match period", 32'(u_far.gap_a[i % 4]), {16'h0, rows[i].gap});
            wr(base | OFS_CTRL, 32'h0);
        end
        // Second reset in mid-run, then reset values
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdc("compare reset", 8'h18, 32'hFF);
        rdc("status reset", OFS_STATUS, 32'h0);
        // Unmapped and misaligned places are refused
        apb(1'b0, 8'h4C, 32'h0);
        chk("unmapped err", 32'(rd_err), 32'h1);
        chk("unmapped data", rd_data, 32'h0);
        apb(1'b1, 8'h06, 32'h5);
        chk("misaligned err", 32'(rd_err), 32'h1);
        // Wrap from maximum: match A, match B and overflow together
        wr(8'h14, 32'hFD);
        wr(8'h10, 32'h1201);
        mark = u_far.cnt_ovf + 1;
        while (u_far.cnt_ovf < mark)
            @(posedge pclk);
        wr(8'h10, 32'h0);
        rdc("wrap flags", OFS_STATUS, 32'h38);
        chk("pin on match", 32'(timer_out), 32'h2);
        // Mask, unmask and clear the overflow interrupt
        wr(OFS_MASK, 32'h20);
        @(negedge pclk);
        chk("irq unmasked", 32'(irq), 32'h1);
        wr(OFS_MASK, 32'h0);
        @(negedge pclk);
        chk("irq masked", 32'(irq), 32'h0);
        wr(OFS_MASK, 32'h20);
        wr(OFS_STATUS, 32'h20);
        @(negedge pclk);
        chk("irq cleared", 32'(irq), 32'h0);
        rdc("flags after clear", OFS_STATUS, 32'h18);
        // External clock edges counted, then an external clear
        wr(8'h20, 32'h1008);
        repeat (5)
        begin
            ext_count_clk[2] <= 1'b1;
            repeat (3) @(posedge pclk);
            ext_count_clk[2] <= 1'b0;
            repeat (3) @(posedge pclk);
        end
        rdc("external count", 8'h24, 32'h5);
        wr(8'h20, 32'h1038);
        ext_count_rst[2] <= 1'b1;
        repeat (3) @(posedge pclk);
        ext_count_rst[2] <= 1'b0;
        rdc("external clear", 8'h24, 32'h0);
        // Link actions: count, restart, start
        wr(8'h30, 32'h1080);
        repeat (3) evt(4'h8);
        rdc("event count", 8'h34, 32'h3);
        wr(8'h30, 32'h10C0);
        evt(4'h8);
        rdc("event restart", 8'h34, 32'h0);
        wr(8'h30, 32'h0041);
        evt(4'h8);
        rdc("event start", 8'h30, 32'h1041);
        wr(8'h30, 32'h0);
        // Cascade: lower byte carries into upper byte
        wr(OFS_UNIT, 32'h1);
        wr(8'h14, 32'hFF);
        wr(8'h00, 32'h1000);
        wr(8'h10, 32'h1080);
        evt(4'h2);
        rdc("lower byte", 8'h14, 32'h0);
        rdc("upper byte", 8'h04, 32'h1);
        // Match count mode, converter start from the second unit
        wr(OFS_UNIT, 32'h49);
        wr(8'h24, 32'hFF);
        wr(8'h20, 32'h1080);
        wr(8'h34, 32'h0);
        wr(8'h30, 32'h1000);
        mark = u_far.cnt_adc;
        evt(4'h4);
        rdc("chained count", 8'h34, 32'h1);
        chk("converter start", 32'(u_far.cnt_adc - mark), 32'h1);
        // Stopped unit ignores its count events
        wr(OFS_UNIT, 32'h69);
        evt(4'h4);
        rdc("stopped count", 8'h24, 32'h0);
        complete_run();
    end
endmodule : testbench

bind ebtp_top ebtp_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .prdata, .pready, .pslverr,
    .timer_out, .link_cma, .link_cmb, .link_ovf, .dtc_req_a, .dtc_req_b, .adc_start, .serial_clk,
    .remote_clk, .irq);
`default_nettype wire
